// file: hdl/aht_trigger.v
// Analog hysteresis trigger with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
`include "aht_consts.vh"

module aht_trigger
(
  input  wire         CLOCK,
  input  wire         RSTN,
  input  wire [4:0]   AVS_ADDRESS,
  input  wire         AVS_READ,
  input  wire         AVS_WRITE,
  input  wire [31:0]  AVS_WRITEDATA,
  input  wire [3:0]   AVS_BYTEENABLE,
  output reg  [31:0]  AVS_READDATA,
  output reg          AVS_WAITREQUEST,
  input  wire [79:0]  ANALOG_INPUT_CHANNELS,
  input  wire [95:0]  ANALOG_FLAG_CELLS,
  input  wire [31:0]  ANALOG_OUTPUT_CHANNELS,
  input  wire [127:0] BLOCK_VALUES,
  output reg          TRIGGER_RESULT,
  output reg          WINDOW_MODE,
  output reg  [23:0]  ACTUAL_VALUE,
  output reg  [1:0]   DECIMALS_COUNT
);

  reg         [14:0] ctrl_r;
  reg  signed [10:0] gain_r;
  reg  signed [14:0] offset_r;
  reg  signed [15:0] set_r;
  reg  signed [15:0] clear_r;

  reg  signed [15:0] sample;
  reg         [9:0]  chan_raw;
  reg  signed [26:0] product;
  reg  signed [26:0] scaled;
  reg  signed [23:0] actual;
  reg  signed [15:0] set_lvl;
  reg  signed [15:0] clear_lvl;
  reg  signed [23:0] set_ext;
  reg  signed [23:0] clear_ext;
  reg                window;
  reg                result_nxt;

  reg         [31:0] old_word;
  reg         [31:0] byte_mask;
  reg  signed [31:0] merged;
  reg  signed [31:0] sat_gain;
  reg  signed [31:0] sat_offset;
  reg  signed [31:0] sat_level;
  reg         [31:0] rd_word;
  reg                wait_nxt;

  wire        [1:0]  src_kind = ctrl_r[`AHT_CTRL_SRC_MSB:`AHT_CTRL_SRC_LSB];
  wire        [2:0]  src_idx  = ctrl_r[`AHT_CTRL_IDX_MSB:`AHT_CTRL_IDX_LSB];
  wire        [2:0]  set_no   = ctrl_r[`AHT_CTRL_SETNO_MSB:`AHT_CTRL_SETNO_LSB];
  wire        [2:0]  clr_no   = ctrl_r[`AHT_CTRL_CLRNO_MSB:`AHT_CTRL_CLRNO_LSB];
  wire               wr_take  = AVS_WRITE & ~AVS_WAITREQUEST;
  wire        [4:0]  word_adr = {AVS_ADDRESS[4:2], 2'b00};

  // Out-of-range writes saturate rather than wrap
  function signed [31:0] aht_sat;
    input signed [31:0] v;
    input signed [31:0] lo;
    input signed [31:0] hi;
    begin
      if (v > hi)
        aht_sat = hi;
      else if (v < lo)
        aht_sat = lo;
      else
        aht_sat = v;
    end
  endfunction

  // Input source selection
  always @*
  begin
    sample   = 16'sh0000;
    chan_raw = ANALOG_INPUT_CHANNELS[src_idx*`AHT_CHAN_W +: `AHT_CHAN_W];
    case (src_kind)
      `AHT_SRC_CHANNEL:
      begin
        if (chan_raw > `AHT_CHAN_MAX) // RULE_10
          sample = {6'h00, `AHT_CHAN_MAX};
        else
          sample = {6'h00, chan_raw};
      end
      `AHT_SRC_FLAG:
      begin
        if (src_idx < `AHT_NUM_FLAGS) // RULE_12
          sample = ANALOG_FLAG_CELLS[src_idx*`AHT_VAL_W +: `AHT_VAL_W];
      end
      `AHT_SRC_OUTPUT:
      begin
        if (src_idx < `AHT_NUM_OUTPUTS) // RULE_12
          sample = ANALOG_OUTPUT_CHANNELS[src_idx*`AHT_VAL_W +: `AHT_VAL_W];
      end
      `AHT_SRC_BLOCK:
        sample = BLOCK_VALUES[src_idx*`AHT_VAL_W +: `AHT_VAL_W]; // RULE_12
      default:
        sample = 16'sh0000;
    endcase
  end

  // Scaling; gain is held in hundredths, so the product is rescaled
  always @*
  begin
    product = sample * gain_r; // RULE_01
    scaled  = product / `AHT_GAIN_SCALE;
    actual  = scaled[23:0] + {{9{offset_r[14]}}, offset_r}; // RULE_01
  end

  // Threshold selection and comparison; decimals never enter here
  always @*
  begin
    set_lvl   = ctrl_r[`AHT_CTRL_SETBLK] ?
                BLOCK_VALUES[set_no*`AHT_VAL_W +: `AHT_VAL_W] : set_r; // RULE_11
    clear_lvl = ctrl_r[`AHT_CTRL_CLRBLK] ?
                BLOCK_VALUES[clr_no*`AHT_VAL_W +: `AHT_VAL_W] : clear_r; // RULE_11
    set_ext   = {{8{set_lvl[15]}}, set_lvl}; // RULE_09
    clear_ext = {{8{clear_lvl[15]}}, clear_lvl}; // RULE_09
    window    = set_ext < clear_ext; // RULE_08
    result_nxt = TRIGGER_RESULT;
    if (window)
      result_nxt = (set_ext <= actual) && (actual < clear_ext); // RULE_08
    else if (actual > set_ext)
      result_nxt = 1'b1; // RULE_06
    else if (actual <= clear_ext)
      result_nxt = 1'b0; // RULE_07
    else
      result_nxt = TRIGGER_RESULT; // RULE_13
  end

  // Register readback
  always @*
  begin
    rd_word = 32'h00000000;
    case (word_adr)
      `AHT_OFS_CTRL:   rd_word = {17'h00000, ctrl_r};
      `AHT_OFS_GAIN:   rd_word = {{21{gain_r[10]}}, gain_r};
      `AHT_OFS_OFFSET: rd_word = {{17{offset_r[14]}}, offset_r};
      `AHT_OFS_SET:    rd_word = {{16{set_r[15]}}, set_r};
      `AHT_OFS_CLEAR:  rd_word = {{16{clear_r[15]}}, clear_r};
      `AHT_OFS_STATUS: rd_word = {30'h00000000, WINDOW_MODE, TRIGGER_RESULT};
      `AHT_OFS_ACTUAL: rd_word = {{8{ACTUAL_VALUE[23]}}, ACTUAL_VALUE};
      default:         rd_word = 32'h00000000;
    endcase
  end

  // Byte-lane merge so partial writes keep untouched lanes
  always @*
  begin
    old_word  = rd_word;
    byte_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                 {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    merged    = (old_word & ~byte_mask) | (AVS_WRITEDATA & byte_mask);
    // Saturated values fit the narrow registers, so the cut loses nothing
    sat_gain   = aht_sat(merged, `AHT_GAIN_MIN, `AHT_GAIN_MAX);
    sat_offset = aht_sat(merged, `AHT_OFFSET_MIN, `AHT_OFFSET_MAX);
    sat_level  = aht_sat(merged, `AHT_LEVEL_MIN, `AHT_LEVEL_MAX);
  end

  // One wait cycle per access, then one ready cycle
  always @*
  begin
    wait_nxt = ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
  end

  always @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
    end
    else
    begin
      AVS_WAITREQUEST <= wait_nxt;
      if (AVS_READ & AVS_WAITREQUEST)
        AVS_READDATA <= rd_word;
    end
  end

  always @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ctrl_r   <= `AHT_RST_CTRL;
      gain_r   <= `AHT_RST_GAIN;
      offset_r <= `AHT_RST_OFFSET;
      set_r    <= `AHT_RST_LEVEL;
      clear_r  <= `AHT_RST_LEVEL;
    end
    else if (wr_take)
    begin
      case (word_adr)
        `AHT_OFS_CTRL:
          ctrl_r <= merged[14:0]; // RULE_05
        `AHT_OFS_GAIN:
          gain_r <= sat_gain[10:0]; // RULE_02
        `AHT_OFS_OFFSET:
          offset_r <= sat_offset[14:0]; // RULE_03
        `AHT_OFS_SET:
          set_r <= sat_level[15:0]; // RULE_04
        `AHT_OFS_CLEAR:
          clear_r <= sat_level[15:0]; // RULE_04
        default:
          ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Result and observed state registered every cycle
  always @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      TRIGGER_RESULT <= 1'b0; // RULE_13
      WINDOW_MODE    <= 1'b0;
      ACTUAL_VALUE   <= 24'h000000;
      DECIMALS_COUNT <= 2'h0;
    end
    else
    begin
      TRIGGER_RESULT <= result_nxt; // RULE_14
      WINDOW_MODE    <= window;
      ACTUAL_VALUE   <= actual;
      DECIMALS_COUNT <= ctrl_r[`AHT_CTRL_DEC_MSB:`AHT_CTRL_DEC_LSB]; // RULE_05
    end
  end

endmodule

`default_nettype wire

// file: hdl/aht_consts.vh
// Constants for the analog hysteresis trigger: offsets, fields, limits
// What this block does
// RULE_01: Actual value is input times multiplier plus offset
// RULE_02: Multiplier accepts signed hundredths, minus ten to ten
// RULE_03: Zero offset accepts signed integers within ten thousand
// RULE_04: Set and clear levels accept plus/minus twenty thousand
// RULE_05: Decimals count takes only zero to three
// RULE_06: Hysteresis: result one when actual exceeds set
// RULE_07: Hysteresis: result zero when actual at/below clear
// RULE_08: Window: one when set <= actual < clear
// RULE_09: Comparisons use raw integers, decimals count ignored
// RULE_10: Analog input channels present values 0 to 1000
// RULE_11: Levels may come from another block's actual value
// RULE_12: Input source: channels, flags, outputs, or block
// RULE_13: Hysteresis band holds result; result resets to zero
// RULE_14: Evaluate every cycle; result registered one cycle later
`ifndef AHT_CONSTS_VH
`define AHT_CONSTS_VH

// Register byte offsets
`define AHT_OFS_CTRL        5'h00
`define AHT_OFS_GAIN        5'h04
`define AHT_OFS_OFFSET      5'h08
`define AHT_OFS_SET         5'h0C
`define AHT_OFS_CLEAR       5'h10
`define AHT_OFS_STATUS      5'h14
`define AHT_OFS_ACTUAL      5'h18

// Control register fields
`define AHT_CTRL_SRC_LSB    0
`define AHT_CTRL_SRC_MSB    1
`define AHT_CTRL_IDX_LSB    2
`define AHT_CTRL_IDX_MSB    4
`define AHT_CTRL_SETBLK     5
`define AHT_CTRL_SETNO_LSB  6
`define AHT_CTRL_SETNO_MSB  8
`define AHT_CTRL_CLRBLK     9
`define AHT_CTRL_CLRNO_LSB  10
`define AHT_CTRL_CLRNO_MSB  12
`define AHT_CTRL_DEC_LSB    13
`define AHT_CTRL_DEC_MSB    14
`define AHT_CTRL_WIDTH      15

// Input source kinds
`define AHT_SRC_CHANNEL     2'h0
`define AHT_SRC_FLAG        2'h1
`define AHT_SRC_OUTPUT      2'h2
`define AHT_SRC_BLOCK       2'h3

// Source counts and widths
`define AHT_NUM_CHANNELS    8
`define AHT_NUM_FLAGS       6
`define AHT_NUM_OUTPUTS     2
`define AHT_NUM_BLOCKS      8
`define AHT_CHAN_W          10
`define AHT_VAL_W           16
`define AHT_ACT_W           24

// Limits (given in hex)
`define AHT_CHAN_MAX        10'h3E8
`define AHT_GAIN_MAX        32'sh000003E8
`define AHT_GAIN_MIN        -32'sh000003E8
`define AHT_OFFSET_MAX      32'sh00002710
`define AHT_OFFSET_MIN      -32'sh00002710
`define AHT_LEVEL_MAX       32'sh00004E20
`define AHT_LEVEL_MIN       -32'sh00004E20
`define AHT_GAIN_SCALE      27'sh0000064

// Reset values
`define AHT_RST_CTRL        15'h0000
`define AHT_RST_GAIN        11'h064
`define AHT_RST_OFFSET      15'h0000
`define AHT_RST_LEVEL       16'h0000

`endif

// file: tb/aht_props.sv
// Port-level assertions for the analog hysteresis trigger
`timescale 1ns/10ps
`default_nettype none
module aht_props (
  input wire logic         CLOCK,
  input wire logic         RSTN,
  input wire logic [4:0]   AVS_ADDRESS,
  input wire logic         AVS_READ,
  input wire logic         AVS_WRITE,
  input wire logic [31:0]  AVS_READDATA,
  input wire logic         AVS_WAITREQUEST,
  input wire logic [127:0] BLOCK_VALUES,
  input wire logic         TRIGGER_RESULT,
  input wire logic         WINDOW_MODE,
  input wire logic [23:0]  ACTUAL_VALUE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  wire rq = AVS_READ | AVS_WRITE;
  wire cm = AVS_WRITE & ~AVS_WAITREQUEST;
  wire rd = AVS_READ & ~AVS_WAITREQUEST;
  wait_one_a: assert property (rq && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered next cycle");
  wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer longer than one cycle");
  wait_idle_a: assert property (!rq |=> AVS_WAITREQUEST)
    else $error("answer without request");
  unmapped_zero_a: assert property (rd && AVS_ADDRESS[4:2] == 3'h7
    |-> AVS_READDATA == 32'h0) else $error("unmapped read not zero");
  status_read_a: assert property (rd && AVS_ADDRESS[4:2] == 3'h5 |->
    AVS_READDATA[1:0] == {$past(WINDOW_MODE), $past(TRIGGER_RESULT)})
    else $error("status readback wrong");
  actual_read_a: assert property (rd && AVS_ADDRESS[4:2] == 3'h6 |->
    AVS_READDATA[23:0] == $past(ACTUAL_VALUE)) else $error("actual wrong");
  actual_range_a: assert property ($signed(ACTUAL_VALUE) <= 24'sd337680 &&
    $signed(ACTUAL_VALUE) >= -24'sd337680) else $error("actual too large");
  result_hold_a: assert property (!cm ##1 $stable(BLOCK_VALUES) ##1
    $stable(ACTUAL_VALUE) |-> $stable(TRIGGER_RESULT))
    else $error("result moved with inputs still");
  cover property ($rose(TRIGGER_RESULT));
  cover property ($fell(TRIGGER_RESULT));
  cover property (WINDOW_MODE && TRIGGER_RESULT);
endmodule
bind aht_trigger aht_props u_props (.CLOCK, .RSTN, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .BLOCK_VALUES,
  .TRIGGER_RESULT, .WINDOW_MODE, .ACTUAL_VALUE);
`default_nettype wire

// file: tb/aht_src_model.sv
// Behavioural model of the analog sources around the trigger
`timescale 1ns/10ps
`default_nettype none
module aht_src_model (
  input  wire logic         clock,
  output var  logic [79:0]  chan,
  output var  logic [95:0]  flag,
  output var  logic [31:0]  aout,
  output var  logic [127:0] blk
);
  initial
  begin
    chan = '0;
    flag = '0;
    aout = '0;
    blk = '0;
  end
  // Values move only right after an edge, as scan data does
  task automatic load(input logic [1:0] kind, input int idx,
                      input logic [15:0] val);
    @(posedge clock);
    case (kind)
      2'h0: chan[idx*10 +: 10] <= val[9:0];
      2'h1: flag[idx*16 +: 16] <= val;
      2'h2: aout[idx*16 +: 16] <= val;
      default: blk[idx*16 +: 16] <= val;
    endcase
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the analog hysteresis trigger
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic         CLOCK = 1'b0;
  logic         RSTN = 1'b0;
  logic [4:0]   AVS_ADDRESS = 5'h00;
  logic         AVS_READ = 1'b0;
  logic         AVS_WRITE = 1'b0;
  logic [31:0]  AVS_WRITEDATA = 32'h0;
  logic [3:0]   be = 4'hF;
  logic [31:0]  q;
  wire  [31:0]  AVS_READDATA;
  wire          AVS_WAITREQUEST;
  wire          TRIGGER_RESULT;
  wire          WINDOW_MODE;
  wire  [23:0]  ACTUAL_VALUE;
  wire  [1:0]   DECIMALS_COUNT;
  wire  [79:0]  chan;
  wire  [95:0]  flag;
  wire  [31:0]  aout;
  wire  [127:0] blk;
  int           fail_count = 0;
  int           checks = 0;
  always #5 CLOCK = ~CLOCK;
  aht_src_model u_src (.clock(CLOCK), .chan, .flag, .aout, .blk);
  aht_trigger u_dut (.CLOCK, .RSTN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE(be), .AVS_READDATA, .AVS_WAITREQUEST,
    .ANALOG_INPUT_CHANNELS(chan), .ANALOG_FLAG_CELLS(flag),
    .ANALOG_OUTPUT_CHANNELS(aout), .BLOCK_VALUES(blk), .TRIGGER_RESULT,
    .WINDOW_MODE, .ACTUAL_VALUE, .DECIMALS_COUNT);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Extra edge after release keeps two requests from sharing a step
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    be <= b;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(q, e);
  endtask
  task automatic outc(input logic [23:0] a, input logic r);
    repeat (3) @(posedge CLOCK);
    chk({8'h00, ACTUAL_VALUE}, {8'h00, a});
    chk({31'h0, TRIGGER_RESULT}, {31'h0, r});
  endtask
  task automatic t_regs;
    rdc(5'h04, 32'h64);
    rdc(5'h1C, 32'h0);
    wr(5'h04, 32'h7D0);
    rdc(5'h04, 32'h3E8);
    bus(1'b1, 5'h04, 32'h32, 4'h1);
    rdc(5'h04, 32'h332);
    wr(5'h08, 32'hFFFFB1E0);
    rdc(5'h08, 32'hFFFFD8F0);
    wr(5'h0C, 32'h7530);
    rdc(5'h0C, 32'h4E20);
  endtask
  task automatic t_hyst;
    logic [15:0] v [6] = '{16'h258, 16'h12C, 16'hC8, 16'h1F4, 16'h1F5,
                           16'h3FC};
    wr(5'h04, 32'h64);
    wr(5'h08, 32'h0);
    wr(5'h0C, 32'h1F4);
    wr(5'h10, 32'hC8);
    for (int i = 0; i < 6; i++)
    begin
      u_src.load(2'h0, 0, v[i]);
      outc((v[i] > 16'h3E8) ? 24'h3E8 : {8'h00, v[i]},
           ((6'h33 >> i) & 6'h01) != 6'h00);
    end
  endtask
  task automatic t_src;
    for (int k = 0; k < 4; k++)
    begin
      wr(5'h00, 32'h4 + k);
      u_src.load(k[1:0], 1, 16'h7B);
      outc(24'h7B, 1'b0);
    end
    wr(5'h00, 32'h9);
    wr(5'h04, 32'hFFFFFF06);
    wr(5'h08, 32'h4D);
    u_src.load(2'h1, 2, 16'hFFD8);
    outc(24'hB1, 1'b0);
    rdc(5'h18, 32'hB1);
  endtask
  task automatic t_win;
    logic [15:0] v [4] = '{16'h64, 16'h12B, 16'h12C, 16'h63};
    wr(5'h00, 32'h6000);
    wr(5'h04, 32'h64);
    wr(5'h08, 32'h0);
    wr(5'h0C, 32'h64);
    wr(5'h10, 32'h12C);
    for (int i = 0; i < 4; i++)
    begin
      u_src.load(2'h0, 0, v[i]);
      outc({8'h00, v[i]}, ((4'h3 >> i) & 4'h1) != 4'h0);
    end
    chk({30'h0, DECIMALS_COUNT}, 32'h3);
    u_src.load(2'h0, 0, 16'h64);
    outc(24'h64, 1'b1);
    rdc(5'h14, 32'h3);
  endtask
  task automatic t_blk;
    wr(5'h00, 32'h16A0);
    u_src.load(2'h3, 2, 16'h190);
    u_src.load(2'h3, 5, 16'h64);
    u_src.load(2'h0, 0, 16'h1C2);
    outc(24'h1C2, 1'b1);
    chk({31'h0, WINDOW_MODE}, 32'h0);
    u_src.load(2'h0, 0, 16'h64);
    outc(24'h64, 1'b0);
  endtask
  task automatic complete_run;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(posedge CLOCK);
    t_regs;
    t_hyst;
    t_src;
    t_win;
    t_blk;
    complete_run;
  end
  initial
  begin
    #50000;
    fail_count++;
    complete_run;
  end
endmodule
`default_nettype wire
